// >>> core/trap_entry_pkg.sv
// Package with register map, field layout and status defaults for the trap entry logic
package trap_entry_pkg;
    // ========================================
    // Register map (byte offsets)
    localparam logic [7:0] TRAP_TABLE_BASE_OFS = 8'h00;
    localparam logic [7:0] NMI_STATUS_OFS = 8'h04;
    localparam logic [7:0] CONTROL_OFS = 8'h08;
    localparam logic [7:0] INTERRUPT_STACK_OFS = 8'h0c;
    localparam logic [7:0] ENTRY_ADDR_OFS = 8'h10;
    localparam logic [7:0] CAUSE_OFS = 8'h14;
    localparam logic [7:0] STATUS_WORD_OFS = 8'h18;
    localparam logic [7:0] STACK_PTR_OFS = 8'h1c;
    // ========================================
    // Reset values and fields
    localparam logic [31:0] TRAP_TABLE_BASE_RESET = 32'ha0000100;
    localparam int CLASS_SHIFT = 5;
    localparam int NMI_EXT_BIT = 0;
    localparam int NMI_PLL_BIT = 1;
    localparam int NMI_WDT_BIT = 2;
    localparam int CTRL_INIT_PROTECT_BIT = 0;
    localparam int CTRL_IE_BIT = 1;
    localparam int CTRL_IS_BIT = 2;
    localparam logic [1:0] ACCESS_PERM_DEFAULT = 2'h2;
    localparam logic [1:0] PROT_SET_DEFAULT = 2'h0;
    localparam logic [6:0] CALL_DEPTH_DEFAULT = 7'h00;
    localparam logic [15:0] WDT_IDLE_WAKE_MASK = 16'h8000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ========================================
    // Carriers
    typedef struct packed {
        logic valid;
        logic [7:0] class_number;
        logic [7:0] ident_number;
        logic context_switch;
    } trap_id_t;

    typedef struct packed {
        logic [1:0] access_permission_field;
        logic [1:0] protection_set_select;
        logic interrupt_stack_select;
        logic [6:0] call_depth_counter;
    } status_word_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAVE = 2'b01,
        ST_FETCH = 2'b11
    } entry_state_t;
endpackage

// >>> core/trap_entry_unit.sv
// Trap entry sequencer with trap table base and non-maskable status register
`timescale 1ns/1ps

// Operation
// - Table base resets to A0000100 hex.
// - Base writable only while init protection open.
// - Entry address is base OR class<<5.
// - Base bit 0 reads zero, ignores writes.
// - Entries eight words apart, never merged.
// - Trap identifier carries class and ident.
// - Save context, clear enable, keep priority.
// - Load status defaults on trap entry.
// - Stack reload from interrupt stack if user.
// - Ident number goes to cause register.
// - Context trap during save preempts interrupt.
// - Status holds pin, lock, watchdog flags.
// - Status read-only, upper bits read zero.
// - Flags ORed into single nonmaskable request.
// - Reading status clears all flags.
// - Pin falling edge sets external flag.
// - Lock loss sets lock loss flag.
// - Watchdog error sets watchdog flag.
// - Idle counter reaching 8000 sets watchdog flag.
module trap_entry_unit
    import trap_entry_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Trap sources
    input wire trap_id_t trap_id,
    input wire logic interrupt_entry,
    input wire logic nmi_pin,
    input wire logic pll_lock_lost,
    input wire logic wdt_error,
    input wire logic cpu_idle,
    input wire logic wdt_enabled,
    input wire logic [15:0] wdt_count,
    // Core side
    output logic save_upper_context,
    output logic fetch_valid,
    output logic [31:0] fetch_addr,
    output logic interrupt_taken,
    output logic interrupt_left_pending,
    output logic nmi_request,
    output logic pll_fallback
);
    // ========================================
    // Registers
    logic [31:0] trap_table_base;
    logic [2:0] nonmaskable_source_status;
    logic init_end_protect;
    logic global_interrupt_enable;
    status_word_t processor_status_word;
    logic [31:0] interrupt_stack_pointer;
    logic [31:0] stack_pointer_reg;
    logic [31:0] cause_data_reg;
    entry_state_t state;
    trap_id_t held_trap;
    logic pin_s1, pin_s2, pin_prev;
    logic [15:0] wdt_count_prev;
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // ========================================
    // Write channel: address and data in either order
    logic do_write;
    assign do_write = aw_held && w_held && !s_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_bvalid <= 1'b0;
            s_bresp <= RESP_OKAY;
            // Readies kept as flops so every port leaves a register
            s_awready <= 1'b1;
            s_wready <= 1'b1;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_held <= 1'b1;
                s_awready <= 1'b0;
                aw_addr <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_held <= 1'b1;
                s_wready <= 1'b0;
                w_data <= s_wdata;
                w_strb <= s_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_awready <= 1'b1;
                s_wready <= 1'b1;
                s_bvalid <= 1'b1;
                case (aw_addr)
                    TRAP_TABLE_BASE_OFS, NMI_STATUS_OFS, CONTROL_OFS,
                    INTERRUPT_STACK_OFS, ENTRY_ADDR_OFS, CAUSE_OFS,
                    STATUS_WORD_OFS, STACK_PTR_OFS: s_bresp <= RESP_OKAY;
                    default: s_bresp <= RESP_SLVERR;
                endcase
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ========================================
    // Trap table base and control
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trap_table_base <= TRAP_TABLE_BASE_RESET;
        end else if (do_write && aw_addr == TRAP_TABLE_BASE_OFS && !init_end_protect) begin
            // gated by init protection; bit 0 forced low
            trap_table_base <= merge(trap_table_base, w_data, w_strb) & ~32'h00000001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            init_end_protect <= 1'b0;
            interrupt_stack_pointer <= 32'h00000000;
        end else if (do_write) begin
            if (aw_addr == CONTROL_OFS && w_strb[0]) begin
                init_end_protect <= w_data[CTRL_INIT_PROTECT_BIT];
            end
            if (aw_addr == INTERRUPT_STACK_OFS) begin
                interrupt_stack_pointer <= merge(interrupt_stack_pointer, w_data, w_strb);
            end
        end
    end

    // ========================================
    // Trap entry sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            held_trap <= '0;
            save_upper_context <= 1'b0;
            fetch_valid <= 1'b0;
            fetch_addr <= 32'h00000000;
            interrupt_taken <= 1'b0;
            interrupt_left_pending <= 1'b0;
        end else begin
            fetch_valid <= 1'b0;
            interrupt_taken <= 1'b0;
            interrupt_left_pending <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (trap_id.valid) begin
                        held_trap <= trap_id;
                        state <= ST_SAVE;
                        save_upper_context <= 1'b1;
                    end else if (interrupt_entry) begin
                        held_trap <= '0;
                        state <= ST_SAVE;
                        save_upper_context <= 1'b1;
                    end
                end
                ST_SAVE: begin
                    save_upper_context <= 1'b0;
                    state <= ST_FETCH;
                    // context trap during save wins, interrupt stays pending
                    if (!held_trap.valid && trap_id.valid && trap_id.context_switch) begin
                        held_trap <= trap_id;
                        interrupt_left_pending <= 1'b1;
                    end
                end
                ST_FETCH: begin
                    state <= ST_IDLE;
                    if (held_trap.valid) begin
                        fetch_valid <= 1'b1;
                        // base OR shifted class; 8-word spacing, no spans
                        fetch_addr <= trap_table_base |
                            (32'(held_trap.class_number) << CLASS_SHIFT);
                    end else begin
                        interrupt_taken <= 1'b1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Status updates on the trap leg of the fetch step
    logic trap_commit;
    assign trap_commit = (state == ST_FETCH) && held_trap.valid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            global_interrupt_enable <= 1'b0;
        end else if (trap_commit) begin
            global_interrupt_enable <= 1'b0;
        end else if (do_write && aw_addr == CONTROL_OFS && w_strb[0]) begin
            global_interrupt_enable <= w_data[CTRL_IE_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            processor_status_word <= '0;
            stack_pointer_reg <= 32'h00000000;
            cause_data_reg <= 32'h00000000;
        end else if (trap_commit) begin
            processor_status_word.access_permission_field <= ACCESS_PERM_DEFAULT;
            processor_status_word.protection_set_select <= PROT_SET_DEFAULT;
            processor_status_word.interrupt_stack_select <= 1'b1;
            processor_status_word.call_depth_counter <= CALL_DEPTH_DEFAULT;
            // only when coming from the user stack
            if (!processor_status_word.interrupt_stack_select) begin
                stack_pointer_reg <= interrupt_stack_pointer;
            end
            cause_data_reg <= {24'h000000, held_trap.ident_number};
        end else if (do_write && aw_addr == CONTROL_OFS && w_strb[0]) begin
            processor_status_word.interrupt_stack_select <= w_data[CTRL_IS_BIT];
        end else if (do_write && aw_addr == STACK_PTR_OFS) begin
            stack_pointer_reg <= merge(stack_pointer_reg, w_data, w_strb);
        end
    end

    // ========================================
    // Nonmaskable sources
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
            pin_prev <= 1'b1;
            wdt_count_prev <= 16'h0000;
        end else begin
            pin_s1 <= nmi_pin;
            pin_s2 <= pin_s1;
            pin_prev <= pin_s2;
            wdt_count_prev <= wdt_count;
        end
    end

    logic ext_event, wdt_event, status_read;
    assign ext_event = pin_prev && !pin_s2;
    // watchdog error; idle wake on bit 15 rising
    assign wdt_event = wdt_error || (cpu_idle && wdt_enabled &&
        ((wdt_count & WDT_IDLE_WAKE_MASK) != 16'h0000) &&
        ((wdt_count_prev & WDT_IDLE_WAKE_MASK) == 16'h0000));
    assign status_read = s_arvalid && s_arready && s_araddr == NMI_STATUS_OFS;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nonmaskable_source_status <= 3'h0;
        end else begin
            // read clears all; new events win over the clear
            if (status_read) begin
                nonmaskable_source_status <= 3'h0;
            end
            if (ext_event) begin
                nonmaskable_source_status[NMI_EXT_BIT] <= 1'b1;
            end
            if (pll_lock_lost) begin
                nonmaskable_source_status[NMI_PLL_BIT] <= 1'b1;
            end
            if (wdt_event) begin
                nonmaskable_source_status[NMI_WDT_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nmi_request <= 1'b0;
            pll_fallback <= 1'b0;
        end else begin
            // one request while any flag set; extra flags add nothing
            nmi_request <= |nonmaskable_source_status;
            // clock loop drops toward base frequency
            pll_fallback <= nonmaskable_source_status[NMI_PLL_BIT];
        end
    end

    // ========================================
    // Read channel, one cycle latency
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b1;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h00000000;
            s_rresp <= RESP_OKAY;
        end else if (s_arvalid && s_arready) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b1;
            s_rresp <= RESP_OKAY;
            case (s_araddr)
                TRAP_TABLE_BASE_OFS: s_rdata <= trap_table_base;
                NMI_STATUS_OFS: s_rdata <= {29'h00000000, nonmaskable_source_status};
                CONTROL_OFS: s_rdata <= {29'h00000000,
                    processor_status_word.interrupt_stack_select,
                    global_interrupt_enable, init_end_protect};
                INTERRUPT_STACK_OFS: s_rdata <= interrupt_stack_pointer;
                ENTRY_ADDR_OFS: s_rdata <= fetch_addr;
                CAUSE_OFS: s_rdata <= cause_data_reg;
                STATUS_WORD_OFS: s_rdata <= {20'h00000, processor_status_word};
                STACK_PTR_OFS: s_rdata <= stack_pointer_reg;
                default: begin
                    s_rdata <= 32'h00000000;
                    s_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_rvalid && s_rready) begin
            s_arready <= 1'b1;
            s_rvalid <= 1'b0;
        end
    end

    // ========================================
    // Elaboration checks on the package
    // Handler entries must stay on even bytes
    if (TRAP_TABLE_BASE_RESET[0] != 1'b0) begin : g_base_align_chk
        $error("table base default must be even");
    end
    // Three flags live in a three-bit register
    if (NMI_EXT_BIT > 2 || NMI_PLL_BIT > 2 || NMI_WDT_BIT > 2) begin : g_flag_pos_chk
        $error("status flag outside the three-bit register");
    end
    // Idle wake watches one counter bit only
    if ($countones(WDT_IDLE_WAKE_MASK) != 1) begin : g_wake_mask_chk
        $error("idle wake mask must hold one bit");
    end
    // Status word read pads twelve bits to a full word
    if ($bits(status_word_t) != 12) begin : g_psw_width_chk
        $error("status word no longer twelve bits");
    end
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the trap entry unit
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    import trap_entry_pkg::*;
    localparam logic [31:0] BASE = 32'h80000e00;
    logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [7:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, fetch_addr, last_fetch, rd;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp, resp;
    trap_id_t trap_id;
    logic interrupt_entry, nmi_pin, pll_lock_lost, wdt_error, cpu_idle, wdt_enabled;
    logic [15:0] wdt_count;
    logic save_upper_context, fetch_valid, interrupt_taken, interrupt_left_pending;
    logic nmi_request, pll_fallback;
    int mismatches = 0;
    int n_tests = 0;
    int fetch_seen = 0;
    int pend_seen = 0;
    int taken_seen = 0;

    trap_entry_unit u_trap_entry_unit (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready,
        .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
        .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .trap_id,
        .interrupt_entry, .nmi_pin, .pll_lock_lost, .wdt_error, .cpu_idle, .wdt_enabled,
        .wdt_count, .save_upper_context, .fetch_valid, .fetch_addr, .interrupt_taken,
        .interrupt_left_pending, .nmi_request, .pll_fallback);
    trap_source_model u_trap_source_model (.aclk, .trap_id, .interrupt_entry, .nmi_pin,
        .pll_lock_lost, .wdt_error, .cpu_idle, .wdt_enabled, .wdt_count);

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (fetch_valid === 1'b1) begin
            fetch_seen++;
            last_fetch = fetch_addr;
        end
        if (interrupt_left_pending === 1'b1) pend_seen++;
        if (interrupt_taken === 1'b1) taken_seen++;
    end
    // ==========
    // Report and bus tasks
    task automatic final_report;
        if (mismatches == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Handshakes judged at the rising edge, as the slave sees them
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_awvalid && s_awready) s_awvalid <= 1'b0;
            if (s_wvalid && s_wready) s_wvalid <= 1'b0;
            if (s_bvalid === 1'b1) done = 1'b1;
        end
        s_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_arvalid && s_arready) s_arvalid <= 1'b0;
            if (s_rvalid === 1'b1) begin
                rd = s_rdata;
                resp = s_rresp;
                done = 1'b1;
            end
        end
        s_rready <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        axi_rd(a);
        `CHK(rd, e)
    endtask
    // ==========
    // Scenarios
    task automatic t_regs;
        rd_chk(TRAP_TABLE_BASE_OFS, TRAP_TABLE_BASE_RESET);
        rd_chk(NMI_STATUS_OFS, 32'h0);
        rd_chk(8'h20, 32'h0);
        `CHK(resp, RESP_SLVERR)
        axi_wr(CONTROL_OFS, 32'h0);
        axi_wr(TRAP_TABLE_BASE_OFS, BASE | 32'h1);
        rd_chk(TRAP_TABLE_BASE_OFS, BASE);
        axi_wr(CONTROL_OFS, 32'h1);
        axi_wr(TRAP_TABLE_BASE_OFS, 32'h40000000);
        rd_chk(TRAP_TABLE_BASE_OFS, BASE);
    endtask
    task automatic t_trap(input logic [7:0] c, input logic [7:0] i, input logic is);
        int old;
        old = fetch_seen;
        axi_wr(CONTROL_OFS, {29'h0, is, 2'b11});
        axi_wr(INTERRUPT_STACK_OFS, 32'h4000);
        axi_wr(STACK_PTR_OFS, 32'h7000);
        u_trap_source_model.raise(c, i, 1'b0, 1'b0);
        for (int n = 0; n < 20 && fetch_seen == old; n++) @(posedge aclk);
        `CHK(fetch_seen, old + 1)
        `CHK(last_fetch, BASE | ({24'h0, c} << CLASS_SHIFT))
        rd_chk(CAUSE_OFS, {24'h0, i});
        rd_chk(STATUS_WORD_OFS, {20'h0, ACCESS_PERM_DEFAULT, PROT_SET_DEFAULT, 1'b1,
            CALL_DEPTH_DEFAULT});
        axi_rd(CONTROL_OFS);
        `CHK(rd[CTRL_IE_BIT], 1'b0)
        rd_chk(STACK_PTR_OFS, is ? 32'h7000 : 32'h4000);
    endtask
    task automatic t_ctx(input logic cs);
        int old, p, t;
        old = fetch_seen;
        p = pend_seen;
        t = taken_seen;
        // Without the context flag the mid-save trap is refused
        u_trap_source_model.raise(8'h03, 8'h05, cs, 1'b1);
        for (int n = 0; n < 20 && fetch_seen == old; n++) @(posedge aclk);
        `CHK(fetch_seen, old + cs)
        `CHK(pend_seen, p + cs)
        `CHK(taken_seen, t + !cs)
        `CHK(last_fetch, BASE | 32'h60)
        rd_chk(CAUSE_OFS, 32'h5);
    endtask
    task automatic t_nmi(input int k);
        u_trap_source_model.fire(k);
        repeat (6) @(posedge aclk);
        `CHK(nmi_request, 1'b1)
        `CHK(pll_fallback, k == 1)
        rd_chk(NMI_STATUS_OFS, 32'h1 << (k == 3 ? 2 : k));
        rd_chk(NMI_STATUS_OFS, 32'h0);
    endtask
    task automatic t_multi;
        u_trap_source_model.fire(1);
        u_trap_source_model.fire(2);
        axi_wr(NMI_STATUS_OFS, 32'h0);
        rd_chk(NMI_STATUS_OFS, 32'h6);
        rd_chk(NMI_STATUS_OFS, 32'h0);
    endtask

    initial begin
        aresetn = 1'b0;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
        {s_awaddr, s_araddr, s_wdata} = '0;
        s_wstrb = 4'hf;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_trap(8'h00, 8'h11, 1'b0);
        t_trap(8'h07, 8'hff, 1'b1);
        t_trap(8'h01, 8'h00, 1'b0);
        t_ctx(1'b1);
        t_ctx(1'b0);
        for (int k = 0; k < 4; k++) t_nmi(k);
        t_multi;
        final_report;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        final_report;
    end
endmodule

// >>> sim/trap_entry_assertions.sv
// Port checker for the trap entry unit
`timescale 1ns/1ps
module trap_entry_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic nmi_pin,
    input wire logic pll_lock_lost,
    input wire logic wdt_error,
    input wire logic cpu_idle,
    input wire logic wdt_enabled,
    input wire logic [15:0] wdt_count,
    input wire logic save_upper_context,
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_addr,
    input wire logic interrupt_taken,
    input wire logic interrupt_left_pending,
    input wire logic nmi_request,
    input wire logic pll_fallback
);
    // ==========
    // Properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence fetch_s;
        ##2 (fetch_valid || interrupt_taken);
    endsequence
    sequence req_s;
        ##2 nmi_request;
    endsequence
    save_fetch_a: assert property (save_upper_context |-> fetch_s)
        else $error("no fetch after context save");
    save_pulse_a: assert property (save_upper_context |=> !save_upper_context)
        else $error("context save longer than one cycle");
    even_entry_a: assert property (fetch_valid |-> !fetch_addr[0])
        else $error("odd trap entry address");
    lock_req_a: assert property (pll_lock_lost |-> req_s)
        else $error("lock loss gave no request");
    lock_fallback_a: assert property (pll_lock_lost |-> ##2 pll_fallback)
        else $error("lock loss gave no fallback");
    wdt_req_a: assert property (wdt_error |-> req_s)
        else $error("watchdog error gave no request");
    idle_wake_a: assert property (
        cpu_idle && wdt_enabled && $rose(wdt_count[15]) |-> ##[2:3] nmi_request)
        else $error("idle wake gave no request");
    pin_fall_a: assert property ($fell(nmi_pin) |-> ##[2:6] nmi_request)
        else $error("pin fall gave no request");
    pend_excl_a: assert property (interrupt_left_pending |-> !interrupt_taken)
        else $error("interrupt both taken and left pending");
endmodule
bind trap_entry_unit trap_entry_assertions u_trap_entry_assertions (.aclk, .aresetn,
    .nmi_pin, .pll_lock_lost, .wdt_error, .cpu_idle, .wdt_enabled, .wdt_count,
    .save_upper_context, .fetch_valid, .fetch_addr, .interrupt_taken,
    .interrupt_left_pending, .nmi_request, .pll_fallback);

// >>> sim/trap_source_model.sv
// Model of the trap, clock-loop, watchdog and pin sources
`timescale 1ns/1ps
module trap_source_model
    import trap_entry_pkg::*;
(
    input wire logic aclk,
    output trap_id_t trap_id,
    output logic interrupt_entry,
    output logic nmi_pin,
    output logic pll_lock_lost,
    output logic wdt_error,
    output logic cpu_idle,
    output logic wdt_enabled,
    output logic [15:0] wdt_count
);
    initial begin
        trap_id = '0;
        interrupt_entry = 1'b0;
        nmi_pin = 1'b1;
        pll_lock_lost = 1'b0;
        wdt_error = 1'b0;
        cpu_idle = 1'b0;
        wdt_enabled = 1'b0;
        wdt_count = 16'h0000;
    end
    // ==========
    // Requests
    // class and ident together
    task automatic raise(input logic [7:0] c, input logic [7:0] i, input logic cs,
        input logic irq);
        @(posedge aclk);
        interrupt_entry <= irq;
        trap_id <= irq ? trap_id_t'('0) : trap_id_t'{1'b1, c, i, cs};
        @(posedge aclk);
        interrupt_entry <= 1'b0;
        // context trap lands during the save
        trap_id <= irq ? trap_id_t'{1'b1, c, i, cs} : trap_id_t'('0);
        @(posedge aclk);
        trap_id <= '0;
    endtask
    task automatic fire(input int k);
        @(posedge aclk);
        case (k)
            0: nmi_pin <= 1'b0;
            1: pll_lock_lost <= 1'b1;
            2: wdt_error <= 1'b1;
            default: begin
                cpu_idle <= 1'b1;
                wdt_enabled <= 1'b1;
                wdt_count <= 16'h7fff;
            end
        endcase
        @(posedge aclk);
        pll_lock_lost <= 1'b0;
        wdt_error <= 1'b0;
        // Outside idle this bit 15 rise must stay silent
        wdt_count <= WDT_IDLE_WAKE_MASK;
        repeat (3) @(posedge aclk);
        nmi_pin <= 1'b1;
        cpu_idle <= 1'b0;
        wdt_enabled <= 1'b0;
        wdt_count <= 16'h0000;
    endtask
endmodule
